/* design/tmss_consts.vh */
// constants for the translation miss and software table search unit
`ifndef TMSS_CONSTS_VH
`define TMSS_CONSTS_VH

// register offsets on the plain register port (byte addresses)
`define TMSS_OFF_CONFIG    8'h00
`define TMSS_OFF_MSTATE    8'h04
`define TMSS_OFF_TABBASE   8'h08
`define TMSS_OFF_SAVED     8'h0C
`define TMSS_OFF_IADDR     8'h10
`define TMSS_OFF_DADDR     8'h14
`define TMSS_OFF_ICOMP     8'h18
`define TMSS_OFF_DCOMP     8'h1C
`define TMSS_OFF_HASHP     8'h20
`define TMSS_OFF_HASHS     8'h24
`define TMSS_OFF_PHYS      8'h28
`define TMSS_OFF_SEG       8'h40
`define TMSS_OFF_IBLK      8'h80
`define TMSS_OFF_DBLK      8'hC0

// field positions (bit 0 is the least significant bit)
`define TMSS_CFG_SWSEARCH  12
`define TMSS_CFG_BLK8      13
`define TMSS_MST_BASE      6
`define TMSS_MST_USER      14
`define TMSS_SAV_KEY       19
`define TMSS_SAV_DI        18
`define TMSS_SAV_WAY       17
`define TMSS_SAV_SL        16
`define TMSS_PHYS_CHANGED  7
`define TMSS_SEG_KS        30
`define TMSS_SEG_KP        29

// reset values
`define TMSS_RST_CONFIG    32'h0000_0000
`define TMSS_RST_MSTATE    32'h0000_0040

// handler vectors
`define TMSS_VEC_IFETCH    32'h0000_1000
`define TMSS_VEC_DLOAD     32'h0000_1100
`define TMSS_VEC_DSTORE    32'h0000_1200
`define TMSS_PREFIX_HIGH   32'hFFF0_0000

// array sizes
`define TMSS_TLB_ENTRIES   128
`define TMSS_BLK_SMALL     4
`define TMSS_BLK_LARGE     8
`define TMSS_SEG_COUNT     16

`endif

/* design/tmss_miss_unit.v */
// translation buffers, block arrays and software table search miss logic
// What this block does
// - fetch address missing both instruction buffer and block array raises instruction miss
// - instruction miss handler starts at prefix base plus 0x01000
// - load address missing data buffer and data block array raises load miss
// - load miss handler starts at prefix base plus 0x01100
// - store address missing data buffer and data block array raises store miss
// - store hitting a data entry with changed bit clear raises store miss
// - store miss handler starts at prefix base plus 0x01200
// - data buffer has 128 entries, two ways; sixteen segment registers exist
// - instruction buffer has 128 entries, two ways
// - block arrays fully associative, 4 or 8 entries by configuration bit
// - configuration bit 12 enables software table search
// - a miss records access and context information before vectoring
// - full 32-bit miss address captured into instruction or data miss register
// - compare word for the faulting access formed automatically on a miss
// - primary and secondary group addresses hashed from miss address, read-only
// - instruction load writes compare and physical words at address and saved way
// - data load writes compare and physical words at address and saved way
// - with software search off, hardware search resolves misses instead
// - saved status holds replacement way; software may overwrite it
// - compare word: valid set, segment id, hash selector clear, page index
// - all older instructions complete before the miss exception is taken
`timescale 1ns/100ps
`include "tmss_consts.vh"

module tmss_miss_unit
#(
	parameter TLB_ENTRIES = `TMSS_TLB_ENTRIES,
	parameter BLK_MAX     = `TMSS_BLK_LARGE
)
(
	input  wire        core_clk,
	input  wire        rst_b,
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWrData,
	input  wire        regWr,
	input  wire        regRd,
	output reg  [31:0] regRdData,
	input  wire        fetchReq,
	input  wire [31:0] fetchAddr,
	input  wire        dataReq,
	input  wire [31:0] dataAddr,
	input  wire        dataStore,
	input  wire        pipeDrained,
	input  wire        loadInstrTlb,
	input  wire        loadDataTlb,
	input  wire [31:0] loadEa,
	input  wire        hwSearchDone,
	input  wire        hwSearchFound,
	input  wire [31:0] hwSearchCmp,
	input  wire [31:0] hwSearchPhys,
	output reg         xlatBusy,
	output reg         xlatDone,
	output reg  [31:0] xlatPhys,
	output reg         xlatRetry,
	output reg         pageFault,
	output reg         holdYounger,
	output reg         excTake,
	output reg  [31:0] excVector,
	output reg         hwSearchReq,
	output reg  [31:0] hwSearchAddr
);

	localparam SETS = TLB_ENTRIES / 2;
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_DRAIN = 3'b010;
	localparam [2:0] ST_HWSRCH = 3'b100;

	reg [31:0] hwConfigTwo;
	reg [31:0] machineStateReg;
	reg [31:0] tableBase;
	reg [31:0] savedStatusReg;
	reg [31:0] instrMissAddress;
	reg [31:0] dataMissAddress;
	reg [31:0] instrCompareWord;
	reg [31:0] dataCompareWord;
	reg [31:0] primaryGroupAddress;
	reg [31:0] secondaryGroupAddress;
	reg [31:0] physicalEntryWord;
	reg [31:0] segReg [0:`TMSS_SEG_COUNT-1];
	reg [31:0] iBlkWord [0:2*BLK_MAX-1];
	reg [31:0] dBlkWord [0:2*BLK_MAX-1];
	reg [31:0] iTlbCmp [0:TLB_ENTRIES-1];
	reg [31:0] iTlbPhys [0:TLB_ENTRIES-1];
	reg [31:0] dTlbCmp [0:TLB_ENTRIES-1];
	reg [31:0] dTlbPhys [0:TLB_ENTRIES-1];
	reg        iLru [0:SETS-1];
	reg        dLru [0:SETS-1];
	reg [2:0]  state;
	reg        pendData;
	reg        pendStore;
	reg        pendWay;
	reg [31:0] pendEa;

	// group address: table origin, masked upper hash bits, low hash bits
	function [31:0] groupAddr;
		input [18:0] hashVal;
		input [31:0] base;
		begin
			groupAddr = {base[31:25], base[24:16] | (hashVal[18:10] & base[8:0]),
				hashVal[9:0], 6'h00};
		end
	endfunction

	// request selection: data side wins when both arrive together
	wire        reqValid = (state == ST_IDLE) && (fetchReq || dataReq);
	wire        reqData = dataReq;
	wire [31:0] reqEa = dataReq ? dataAddr : fetchAddr;
	wire        reqStore = dataReq && dataStore;
	wire [5:0]  reqSet = reqEa[17:12];
	wire [31:0] reqSeg = segReg[reqEa[31:28]];
	// compare word layout: valid, segment id, hash select clear, page index
	wire [31:0] expCmp = {1'b1, reqSeg[23:0], 1'b0, reqEa[27:22]};
	wire [18:0] hashOne = reqSeg[18:0] ^ {3'b000, reqEa[27:12]};
	wire        swSearch = hwConfigTwo[`TMSS_CFG_SWSEARCH];
	wire [3:0]  blkCount = hwConfigTwo[`TMSS_CFG_BLK8] ? 4'd`TMSS_BLK_LARGE
		: 4'd`TMSS_BLK_SMALL;

	// two-way lookup in the set addressed by the page number
	wire [31:0] way0Cmp = reqData ? dTlbCmp[{reqSet, 1'b0}] : iTlbCmp[{reqSet, 1'b0}];
	wire [31:0] way1Cmp = reqData ? dTlbCmp[{reqSet, 1'b1}] : iTlbCmp[{reqSet, 1'b1}];
	wire [31:0] way0Phys = reqData ? dTlbPhys[{reqSet, 1'b0}] : iTlbPhys[{reqSet, 1'b0}];
	wire [31:0] way1Phys = reqData ? dTlbPhys[{reqSet, 1'b1}] : iTlbPhys[{reqSet, 1'b1}];
	wire        hit0 = (way0Cmp == expCmp);
	wire        hit1 = (way1Cmp == expCmp);
	wire [31:0] tlbPhys = hit0 ? way0Phys : way1Phys;
	wire        tlbHit = hit0 || hit1;
	wire        lruWay = reqData ? dLru[reqSet] : iLru[reqSet];

	// fully associative block search over the enabled entries
	reg        blkHit;
	reg [31:0] blkPhys;
	reg [31:0] blkUpper;
	reg [31:0] blkLower;
	integer    b;
	always @*
	begin
		blkHit = 1'b0;
		blkPhys = 32'h0000_0000;
		blkUpper = 32'h0000_0000;
		blkLower = 32'h0000_0000;
		for (b = BLK_MAX - 1; b >= 0; b = b - 1)
		begin
			blkUpper = reqData ? dBlkWord[2*b] : iBlkWord[2*b];
			blkLower = reqData ? dBlkWord[2*b+1] : iBlkWord[2*b+1];
			if (b < blkCount && blkUpper[0] && blkUpper[31:17] == reqEa[31:17])
			begin
				blkHit = 1'b1;
				blkPhys = {blkLower[31:17], reqEa[16:0]};
			end
		end
	end

	// a store to a clean page must trap so the changed bit gets set
	wire cleanStore = reqStore && !blkHit && !tlbPhys[`TMSS_PHYS_CHANGED];
	wire resolved = blkHit || (tlbHit && !cleanStore);
	wire missEvent = reqValid && !resolved;

	// key bit picks the supervisor or user key of the segment
	wire keyBit = machineStateReg[`TMSS_MST_USER] ? reqSeg[`TMSS_SEG_KP] : reqSeg[`TMSS_SEG_KS];
	wire [31:0] prefixBase = machineStateReg[`TMSS_MST_BASE] ? `TMSS_PREFIX_HIGH : 32'h0000_0000;

	// register writes, miss capture and buffer loads share one process
	integer k;
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			hwConfigTwo <= `TMSS_RST_CONFIG;
			machineStateReg <= `TMSS_RST_MSTATE;
			tableBase <= 32'h0000_0000;
			savedStatusReg <= 32'h0000_0000;
			instrMissAddress <= 32'h0000_0000;
			dataMissAddress <= 32'h0000_0000;
			instrCompareWord <= 32'h0000_0000;
			dataCompareWord <= 32'h0000_0000;
			primaryGroupAddress <= 32'h0000_0000;
			secondaryGroupAddress <= 32'h0000_0000;
			physicalEntryWord <= 32'h0000_0000;
			for (k = 0; k < `TMSS_SEG_COUNT; k = k + 1)
				segReg[k] <= 32'h0000_0000;
			for (k = 0; k < 2 * BLK_MAX; k = k + 1)
			begin
				iBlkWord[k] <= 32'h0000_0000;
				dBlkWord[k] <= 32'h0000_0000;
			end
			for (k = 0; k < TLB_ENTRIES; k = k + 1)
			begin
				iTlbCmp[k] <= 32'h0000_0000;
				iTlbPhys[k] <= 32'h0000_0000;
				dTlbCmp[k] <= 32'h0000_0000;
				dTlbPhys[k] <= 32'h0000_0000;
			end
			for (k = 0; k < SETS; k = k + 1)
			begin
				iLru[k] <= 1'b0;
				dLru[k] <= 1'b0;
			end
		end
		else
		begin
			// software writes; miss registers and hash registers stay read-only
			if (regWr)
			begin
				case (regAddr)
					`TMSS_OFF_CONFIG:  hwConfigTwo <= regWrData;
					`TMSS_OFF_MSTATE:  machineStateReg <= regWrData;
					`TMSS_OFF_TABBASE: tableBase <= regWrData;
					`TMSS_OFF_SAVED:   savedStatusReg <= regWrData;
					`TMSS_OFF_PHYS:    physicalEntryWord <= regWrData;
					default:
					begin
						if (regAddr[7:6] == 2'b01)
							segReg[regAddr[5:2]] <= regWrData;
						else if (regAddr[7:6] == 2'b10)
							iBlkWord[regAddr[5:2]] <= regWrData;
						else if (regAddr[7:6] == 2'b11)
							dBlkWord[regAddr[5:2]] <= regWrData;
					end
				endcase
			end
			// hits refresh the replacement choice of their set
			if (reqValid && tlbHit && !blkHit)
			begin
				if (reqData)
					dLru[reqSet] <= hit0;
				else
					iLru[reqSet] <= hit0;
			end
			// capture on a software miss; beats a same-cycle software write
			if (missEvent && swSearch)
			begin
				if (reqData)
				begin
					dataMissAddress <= reqEa;
					dataCompareWord <= expCmp;
				end
				else
				begin
					instrMissAddress <= reqEa;
					instrCompareWord <= expCmp;
				end
				primaryGroupAddress <= groupAddr(hashOne, tableBase);
				secondaryGroupAddress <= groupAddr(~hashOne, tableBase);
				savedStatusReg[`TMSS_SAV_KEY] <= keyBit;
				savedStatusReg[`TMSS_SAV_DI] <= !reqData;
				savedStatusReg[`TMSS_SAV_WAY] <= lruWay;
				savedStatusReg[`TMSS_SAV_SL] <= reqStore;
			end
			// software buffer loads use the operand address and the saved way
			if (loadInstrTlb)
			begin
				iTlbCmp[{loadEa[17:12], savedStatusReg[`TMSS_SAV_WAY]}] <= instrCompareWord;
				iTlbPhys[{loadEa[17:12], savedStatusReg[`TMSS_SAV_WAY]}] <= physicalEntryWord;
				iLru[loadEa[17:12]] <= !savedStatusReg[`TMSS_SAV_WAY];
			end
			if (loadDataTlb)
			begin
				dTlbCmp[{loadEa[17:12], savedStatusReg[`TMSS_SAV_WAY]}] <= dataCompareWord;
				dTlbPhys[{loadEa[17:12], savedStatusReg[`TMSS_SAV_WAY]}] <= physicalEntryWord;
				dLru[loadEa[17:12]] <= !savedStatusReg[`TMSS_SAV_WAY];
			end
			// hardware search fills the replacement way directly
			if (state == ST_HWSRCH && hwSearchDone && hwSearchFound)
			begin
				if (pendData)
				begin
					dTlbCmp[{pendEa[17:12], pendWay}] <= hwSearchCmp;
					dTlbPhys[{pendEa[17:12], pendWay}] <= hwSearchPhys;
					dLru[pendEa[17:12]] <= !pendWay;
				end
				else
				begin
					iTlbCmp[{pendEa[17:12], pendWay}] <= hwSearchCmp;
					iTlbPhys[{pendEa[17:12], pendWay}] <= hwSearchPhys;
					iLru[pendEa[17:12]] <= !pendWay;
				end
			end
		end
	end

	// miss sequencer: drain older work, then vector, or hand to the walker
	always @(posedge core_clk)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			pendData <= 1'b0;
			pendStore <= 1'b0;
			pendWay <= 1'b0;
			pendEa <= 32'h0000_0000;
			xlatBusy <= 1'b0;
			xlatDone <= 1'b0;
			xlatPhys <= 32'h0000_0000;
			xlatRetry <= 1'b0;
			pageFault <= 1'b0;
			holdYounger <= 1'b0;
			excTake <= 1'b0;
			excVector <= 32'h0000_0000;
			hwSearchReq <= 1'b0;
			hwSearchAddr <= 32'h0000_0000;
		end
		else
		begin
			xlatDone <= 1'b0;
			xlatRetry <= 1'b0;
			pageFault <= 1'b0;
			excTake <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (reqValid && resolved)
					begin
						xlatDone <= 1'b1;
						xlatPhys <= blkHit ? blkPhys : {tlbPhys[31:12], reqEa[11:0]};
					end
					else if (missEvent)
					begin
						pendData <= reqData;
						pendStore <= reqStore;
						pendWay <= lruWay;
						pendEa <= reqEa;
						xlatBusy <= 1'b1;
						holdYounger <= 1'b1;
						if (swSearch)
							state <= ST_DRAIN;
						else
						begin
							state <= ST_HWSRCH;
							hwSearchReq <= 1'b1;
							hwSearchAddr <= reqEa;
						end
					end
				end
				ST_DRAIN:
				begin
					// only once every older instruction has completed
					if (pipeDrained)
					begin
						excTake <= 1'b1;
						if (!pendData)
							excVector <= prefixBase | `TMSS_VEC_IFETCH;
						else if (pendStore)
							excVector <= prefixBase | `TMSS_VEC_DSTORE;
						else
							excVector <= prefixBase | `TMSS_VEC_DLOAD;
						xlatBusy <= 1'b0;
						holdYounger <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_HWSRCH:
				begin
					if (hwSearchDone)
					begin
						hwSearchReq <= 1'b0;
						xlatRetry <= hwSearchFound;
						pageFault <= !hwSearchFound;
						xlatBusy <= 1'b0;
						holdYounger <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// read data stand in the cycle after the strobe and read zero otherwise
	always @(posedge core_clk)
	begin
		if (!rst_b)
			regRdData <= 32'h0000_0000;
		else if (!regRd)
			regRdData <= 32'h0000_0000;
		else
		begin
			case (regAddr)
				`TMSS_OFF_CONFIG:  regRdData <= hwConfigTwo;
				`TMSS_OFF_MSTATE:  regRdData <= machineStateReg;
				`TMSS_OFF_TABBASE: regRdData <= tableBase;
				`TMSS_OFF_SAVED:   regRdData <= savedStatusReg;
				`TMSS_OFF_IADDR:   regRdData <= instrMissAddress;
				`TMSS_OFF_DADDR:   regRdData <= dataMissAddress;
				`TMSS_OFF_ICOMP:   regRdData <= instrCompareWord;
				`TMSS_OFF_DCOMP:   regRdData <= dataCompareWord;
				`TMSS_OFF_HASHP:   regRdData <= primaryGroupAddress;
				`TMSS_OFF_HASHS:   regRdData <= secondaryGroupAddress;
				`TMSS_OFF_PHYS:    regRdData <= physicalEntryWord;
				default:
				begin
					if (regAddr[7:6] == 2'b01)
						regRdData <= segReg[regAddr[5:2]];
					else if (regAddr[7:6] == 2'b10)
						regRdData <= iBlkWord[regAddr[5:2]];
					else if (regAddr[7:6] == 2'b11)
						regRdData <= dBlkWord[regAddr[5:2]];
					else
						regRdData <= 32'h0000_0000; // unmapped reads as zero
				end
			endcase
		end
	end

endmodule

/* test/tmss_miss_unit_properties.sv */
// assertions on the translation miss unit ports
`timescale 1ns/100ps
module tmss_miss_unit_properties
(
	input logic        core_clk,
	input logic        rst_b,
	input logic        fetchReq,
	input logic        dataReq,
	input logic        dataStore,
	input logic        pipeDrained,
	input logic        hwSearchDone,
	input logic        hwSearchFound,
	input logic        xlatBusy,
	input logic        xlatDone,
	input logic        xlatRetry,
	input logic        pageFault,
	input logic        holdYounger,
	input logic        excTake,
	input logic [31:0] excVector,
	input logic        hwSearchReq
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	// request taken while idle that leaves a software miss pending
	sequence swMiss;
		!xlatBusy && (fetchReq || dataReq) ##1 xlatBusy && !hwSearchReq;
	endsequence
	sequence storeMiss;
		!xlatBusy && dataReq && dataStore ##1 xlatBusy && !hwSearchReq;
	endsequence

	chk_drain_first: assert property (excTake |-> $past(pipeDrained) && $past(xlatBusy))
		else $error("exception taken before older work drained");
	chk_hold_pending: assert property (xlatBusy && !hwSearchReq |-> holdYounger)
		else $error("younger work not held during a pending miss");
	chk_exc_release: assert property (excTake |-> !xlatBusy && !holdYounger ##1 !excTake)
		else $error("exception pulse or release wrong");
	chk_miss_vectors: assert property (swMiss |-> ##[1:20] excTake)
		else $error("pending miss never vectored");
	chk_store_vector: assert property (storeMiss |-> ##[1:20] excTake && excVector[15:8] == 8'h12)
		else $error("store miss vector wrong");
	chk_vector_base: assert property (excTake |-> excVector[7:0] == 8'h00 &&
		excVector[15:8] inside {8'h10, 8'h11, 8'h12} && excVector[31:16] inside {16'h0, 16'hFFF0})
		else $error("handler address off the allowed set");
	chk_hw_answer: assert property (hwSearchReq && hwSearchDone |=> !hwSearchReq && !xlatBusy &&
		xlatRetry == $past(hwSearchFound) && pageFault != xlatRetry)
		else $error("walker answer not turned into retry or fault");
	chk_hit_timing: assert property (xlatDone |-> !$past(xlatBusy) && $past(fetchReq || dataReq))
		else $error("hit reported without an accepted request");
endmodule

bind tmss_miss_unit tmss_miss_unit_properties i_chk (.core_clk, .rst_b, .fetchReq, .dataReq,
	.dataStore, .pipeDrained, .hwSearchDone, .hwSearchFound, .xlatBusy, .xlatDone, .xlatRetry,
	.pageFault, .holdYounger, .excTake, .excVector, .hwSearchReq);

/* test/tmss_walker_model.sv */
// hardware table walker model answering search requests after a set delay
`timescale 1ns/100ps
module tmss_walker_model
(
	input  logic        core_clk,
	input  logic        rst_b,
	input  logic        hwSearchReq,
	input  logic [31:0] hwSearchAddr,
	input  logic [3:0]  delay,
	input  logic        found,
	output logic        hwSearchDone,
	output logic        hwSearchFound,
	output logic [31:0] hwSearchCmp,
	output logic [31:0] hwSearchPhys
);
	logic [3:0] waitCnt;

	// one answer per request while delay is below 4'hF; data lines toggle outside the answer cycle
	always @(posedge core_clk)
	begin
		hwSearchDone <= 1'b0;
		hwSearchFound <= ~hwSearchFound;
		hwSearchCmp <= ~hwSearchCmp;
		hwSearchPhys <= ~hwSearchPhys;
		if (!rst_b)
		begin
			{hwSearchFound, hwSearchCmp, hwSearchPhys} <= 65'h0;
			waitCnt <= 4'h0;
		end
		else if (!hwSearchReq)
			waitCnt <= 4'h0;
		else if (waitCnt == delay)
		begin
			hwSearchDone <= 1'b1;
			hwSearchFound <= found;
			hwSearchCmp <= 32'h8000_0000 | hwSearchAddr[27:22];
			hwSearchPhys <= {~hwSearchAddr[31:12], 12'h080};
			waitCnt <= 4'hF; // request lingers a cycle; no second answer while delay is below 4'hF
		end
		else if (waitCnt != 4'hF)
			waitCnt <= waitCnt + 4'h1;
	end
endmodule

/* test/tmss_miss_unit_test.sv */
// self-checking bench for the translation miss unit
`timescale 1ns/100ps
`include "tmss_consts.vh"
module tmss_miss_unit_test;
	typedef struct packed {logic [2:0] k; logic [31:0] m; logic [31:0] v;} tmss_exp_t;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic        regWr, regRd, fetchReq, dataReq, dataStore, pipeDrained, rdLast;
	logic        loadInstrTlb, loadDataTlb, hwSearchDone, hwSearchFound, xlatBusy, xlatDone;
	logic        xlatRetry, pageFault, holdYounger, excTake, hwSearchReq, walkFound;
	logic [3:0]  walkDelay;
	logic [31:0] regWrData, regRdData, fetchAddr, dataAddr, loadEa, hwSearchCmp, hwSearchPhys;
	logic [31:0] xlatPhys, excVector, hwSearchAddr, a;
	tmss_exp_t   expQ[$];
	int          mismatches = 0;
	int          tests_run = 0;
	int          cycles = 0;

	tmss_miss_unit i_dut (.core_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
		.fetchReq, .fetchAddr, .dataReq, .dataAddr, .dataStore, .pipeDrained, .loadInstrTlb,
		.loadDataTlb, .loadEa, .hwSearchDone, .hwSearchFound, .hwSearchCmp, .hwSearchPhys,
		.xlatBusy, .xlatDone, .xlatPhys, .xlatRetry, .pageFault, .holdYounger, .excTake,
		.excVector, .hwSearchReq, .hwSearchAddr);
	tmss_walker_model i_walk (.core_clk, .rst_b, .hwSearchReq, .hwSearchAddr, .delay(walkDelay),
		.found(walkFound), .hwSearchDone, .hwSearchFound, .hwSearchCmp, .hwSearchPhys);

	always #50 core_clk = ~core_clk;

	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// oldest note against the result just seen; a result with no note fails
	task automatic check(input logic [2:0] k, input logic [31:0] got);
		tmss_exp_t e;
		e = '{3'h7, 32'h0, 32'h0};
		tests_run++;
		if (expQ.size() != 0)
			e = expQ.pop_front();
		if (e.k !== k || (got & e.m) !== e.v)
		begin
			mismatches++;
			$display("[ERR] t=%0t kind %0h exp %h got %h", $time, k, e.v, got);
		end
	endtask

	// watch results mid-cycle, once the edge updates have landed
	always @(negedge core_clk)
	begin
		if (rdLast)
			check(3'h0, regRdData);
		if (excTake === 1'b1)
			check(3'h1, excVector);
		if (xlatDone === 1'b1)
			check(3'h2, xlatPhys);
		if (xlatRetry === 1'b1)
			check(3'h3, 32'h0);
		if (pageFault === 1'b1)
			check(3'h4, 32'h0);
	end

	// read data belongs to the cycle after the strobe; also cut a hang short
	always @(posedge core_clk)
	begin
		rdLast <= regRd;
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			final_report();
		end
	end

	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= ad;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, input logic [31:0] m, input logic [31:0] v);
		expQ.push_back('{3'h0, m, v & m});
		@(posedge core_clk);
		regAddr <= ad;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
	endtask

	// one translate request; older work drains three cycles after it
	task automatic xl(input logic d, input logic s, input logic [31:0] ad, input logic [2:0] k,
		input logic [31:0] v);
		expQ.push_back('{k, 32'hFFFF_FFFF, v});
		@(posedge core_clk);
		dataReq <= d;
		fetchReq <= !d;
		dataStore <= s;
		dataAddr <= ad;
		fetchAddr <= ad;
		@(posedge core_clk);
		dataReq <= 1'b0;
		fetchReq <= 1'b0;
		repeat (3) @(posedge core_clk);
		pipeDrained <= 1'b1;
		repeat (30) @(negedge core_clk) if (xlatBusy === 1'b0) break;
		@(posedge core_clk);
		pipeDrained <= 1'b0;
	endtask

	// handler side: fix the way, supply the entry word, then load the buffer
	task automatic ld(input logic d, input logic [31:0] ea, input logic [31:0] pw);
		wr(`TMSS_OFF_SAVED, 32'h0);
		wr(`TMSS_OFF_PHYS, pw);
		@(posedge core_clk);
		loadEa <= ea;
		loadDataTlb <= d;
		loadInstrTlb <= !d;
		@(posedge core_clk);
		loadDataTlb <= 1'b0;
		loadInstrTlb <= 1'b0;
	endtask

	initial
	begin
		{regWr, regRd, fetchReq, dataReq, dataStore, pipeDrained, rdLast} = 7'h00;
		{loadInstrTlb, loadDataTlb, regWrData, fetchAddr, dataAddr, loadEa} = 130'h0;
		walkDelay = 4'h2;
		walkFound = 1'b1;
		a = $urandom(32'hE18A);
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		rd(`TMSS_OFF_CONFIG, 32'hFFFF_FFFF, `TMSS_RST_CONFIG);
		rd(`TMSS_OFF_MSTATE, 32'hFFFF_FFFF, `TMSS_RST_MSTATE);
		a = $urandom;
		xl(1'b1, 1'b0, a, 3'h3, 32'h0);
		xl(1'b1, 1'b0, a, 3'h2, {~a[31:12], a[11:0]});
		walkDelay <= 4'h9;
		walkFound <= 1'b0;
		xl(1'b0, 1'b0, $urandom, 3'h4, 32'h0);
		wr(`TMSS_OFF_CONFIG, 32'h0000_1000);
		rd(`TMSS_OFF_CONFIG, 32'hFFFF_FFFF, 32'h0000_1000);
		for (int p = 0; p < 2; p++)
		begin
			// one address for all three kinds, so the buffer loads below see its compare words
			a = $urandom;
			for (int k = 0; k < 3; k++)
			begin
				xl(k != 0, k == 2, a, 3'h1, (p ? 32'h0 : `TMSS_PREFIX_HIGH) |
					(`TMSS_VEC_IFETCH + k * 32'h100));
				rd(k ? `TMSS_OFF_DADDR : `TMSS_OFF_IADDR, 32'hFFFF_FFFF, a);
				rd(k ? `TMSS_OFF_DCOMP : `TMSS_OFF_ICOMP, 32'hFFFF_FFFF,
					32'h8000_0000 | a[27:22]);
				rd(`TMSS_OFF_HASHP, 32'hFFFF_FFFF, {16'h0, a[21:12], 6'h0});
				rd(`TMSS_OFF_HASHS, 32'hFFFF_FFFF, {16'h0, ~a[21:12], 6'h0});
				rd(`TMSS_OFF_SAVED, 32'h0005_0000, {(k == 0), 1'b0, (k == 2), 16'h0});
				// handler side: the machine state is written back to this pass's value and read again
				wr(`TMSS_OFF_MSTATE, p ? 32'h0 : `TMSS_RST_MSTATE);
				rd(`TMSS_OFF_MSTATE, 32'hFFFF_FFFF, p ? 32'h0 : `TMSS_RST_MSTATE);
			end
			wr(`TMSS_OFF_MSTATE, 32'h0);
		end
		wr(`TMSS_OFF_HASHP, 32'hFFFF_FFFF);
		rd(`TMSS_OFF_HASHP, 32'hFFFF_FFFF, {16'h0, a[21:12], 6'h0});
		rd(8'h30, 32'hFFFF_FFFF, 32'h0);
		ld(1'b0, a, {~a[31:12], 12'h080});
		xl(1'b0, 1'b0, a, 3'h2, {~a[31:12], a[11:0]});
		ld(1'b1, a, {~a[31:12], 12'h000});
		xl(1'b1, 1'b1, a, 3'h1, `TMSS_VEC_DSTORE);
		xl(1'b1, 1'b0, a, 3'h2, {~a[31:12], a[11:0]});
		ld(1'b1, a, {~a[31:12], 12'h080});
		xl(1'b1, 1'b1, a, 3'h2, {~a[31:12], a[11:0]});
		// data block entry 5 only counts once eight entries are selected
		a = $urandom;
		wr(`TMSS_OFF_DBLK + 8'h28, {a[31:17], 16'h0000, 1'b1});
		wr(`TMSS_OFF_DBLK + 8'h2C, {~a[31:17], 17'h0_0000});
		xl(1'b1, 1'b0, a, 3'h1, `TMSS_VEC_DLOAD);
		wr(`TMSS_OFF_CONFIG, 32'h0000_3000);
		xl(1'b1, 1'b0, a, 3'h2, {~a[31:17], a[16:0]});
		repeat (4) @(posedge core_clk);
		tests_run++;
		if (expQ.size() != 0)
		begin
			mismatches++;
			$display("[ERR] t=%0t left %h got %h", $time, 32'h0, expQ.size());
		end
		final_report();
	end
endmodule
